// ==== verilog/asp_pkg.sv ====
package asp_pkg;

  // Register offsets (byte addresses, one aligned word each; INFO and EXT start eight-word blocks)
  localparam logic [11:0] ASP_OFF_CTRL     = 12'h000;
  localparam logic [11:0] ASP_OFF_CHANNELS = 12'h004;
  localparam logic [11:0] ASP_OFF_M        = 12'h008;
  localparam logic [11:0] ASP_OFF_N        = 12'h00C;
  localparam logic [11:0] ASP_OFF_CLKMODE  = 12'h010;
  localparam logic [11:0] ASP_OFF_STATUS   = 12'h014;
  localparam logic [11:0] ASP_OFF_M_ACT    = 12'h018;
  localparam logic [11:0] ASP_OFF_N_ACT    = 12'h01C;
  localparam logic [11:0] ASP_OFF_INFO     = 12'h020;
  localparam logic [11:0] ASP_OFF_EXT      = 12'h040;

  // Field positions
  localparam int ASP_CTRL_EN_BIT      = 0;
  localparam int ASP_CLKMODE_SYNC_BIT = 0;
  localparam int ASP_ST_ENABLED_BIT   = 0;
  localparam int ASP_ST_EXT_BUSY_BIT  = 1;
  localparam int ASP_ST_EXT_SENT_BIT  = 2;
  localparam int ASP_ST_INFO_OK_BIT   = 3;
  localparam int ASP_ST_MUTE_BIT      = 4;

  // Reset values
  localparam logic [31:0] ASP_RST_M        = 32'h0000_0000;
  localparam logic [31:0] ASP_RST_N        = 32'h0000_0000;
  localparam logic [2:0]  ASP_RST_CHANNELS = 3'h1;

  // Packet geometry and timing
  localparam int ASP_HDR_BYTES       = 4;
  localparam int ASP_HDR_PAR_BYTES   = 4;
  localparam int ASP_PAY_BYTES       = 32;
  localparam int ASP_PAY_PAR_BYTES   = 8;
  localparam int ASP_PKT_BYTES       = ASP_HDR_BYTES + ASP_HDR_PAR_BYTES + ASP_PAY_BYTES + ASP_PAY_PAR_BYTES;
  localparam int ASP_PKT_WORDS       = 8;
  localparam int ASP_INFO_PERIOD_CYC = 8192;
  localparam int ASP_REF_RATIO       = 512;
  localparam int ASP_NAUD_ASYNC      = 32768;

  // Packet type codes in header byte 1
  localparam logic [7:0] ASP_TYPE_AUDIO = 8'h02;
  localparam logic [7:0] ASP_TYPE_INFO  = 8'h84;
  localparam logic [7:0] ASP_TYPE_EXT   = 8'h04;

  typedef enum logic [1:0] {
    ASP_KIND_AUDIO = 2'h0,
    ASP_KIND_INFO  = 2'h1,
    ASP_KIND_EXT   = 2'h2
  } asp_kind_t;

  typedef enum logic [2:0] {
    ASP_S_IDLE = 3'b001,
    ASP_S_LOAD = 3'b010,
    ASP_S_SEND = 3'b100
  } asp_state_t;

endpackage : asp_pkg

// ==== verilog/asp_sample_mem.sv ====
`timescale 1ns/10ps
module asp_sample_mem #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  // Clock
  input  wire logic                     clk,
  input  wire logic                     ce,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port, data one cycle after rd_en
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("asp_sample_mem: DEPTH must be a power of two");
  end

  // No reset on the array so it maps onto block or distributed RAM
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : asp_sample_mem

// ==== verilog/asp_packetizer.sv ====
// Summary of operation
// RL1 - Stream word holds control bits, a 24-bit sample and a preamble.
// RL2 - A sample enters the buffer only when tvalid and tready are both high.
// RL3 - Ready is granted only with buffer room and audio enabled.
// RL4 - Packet is 4 header, 4 parity, 32 payload and 8 parity bytes.
// RL5 - Eight buffered samples are gathered before one audio packet goes out.
// RL6 - Host sets up the info frame before multi-channel audio.
// RL7 - Source puts the channel identifier on tid with every sample.
// RL8 - For multi-stream audio tid upper nibble matches the info packet ID.
// RL9 - Writing zero to control disables audio, flushes buffers, sets mute.
// RL10 - Channel count register holds active channels minus one.
// RL11 - In synchronous mode host writes M and N before enabling.
// RL12 - In asynchronous mode M and N come from the 512 fs reference clock.
// RL13 - Audio starts only after control is written with one, last.
// RL14 - Info packet is loaded with exactly eight ordered writes.
// RL15 - Info packet is sent once per video frame or every 8192 cycles.
// RL16 - Host disables audio and reprograms fully to change the info packet.
// RL17 - One extension buffer, sent as soon as the channel is free.
// RL18 - Extension packet is exactly eight words long.
// RL19 - Host waits for the sent indication before the next extension packet.
// RL20 - Reprogramming: disable, wait for stable clocks, enable, then settle.
// RL21 - Sent indication fires after the extension packet, buffer then free.
// RL22 - While disabled, ready stays low and no audio packet is sent.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module asp_packetizer
  import asp_pkg::*;
#(
  parameter int INFO_PERIOD = ASP_INFO_PERIOD_CYC,
  parameter int NAUD_ASYNC  = ASP_NAUD_ASYNC,
  parameter int BUF_DEPTH   = 16
) (
  // Clock, enable and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Audio stream in
  input  wire logic [31:0] s_axis_audio_tdata,
  input  wire logic [7:0]  s_axis_audio_tid,
  input  wire logic        s_axis_audio_tvalid,
  output logic             s_axis_audio_tready,
  // Video frame marker and audio reference clock pin
  input  wire logic        frame_start,
  input  wire logic        aud_ref_clk,
  // Secondary packet byte stream to the main link
  output logic      [7:0]  sec_data,
  output logic             sec_valid,
  input  wire logic        sec_ready,
  output logic      [1:0]  sec_kind,
  output logic             sec_sop,
  output logic             sec_eop,
  // Status outputs
  output logic             vbid_mute,
  output logic      [31:0] aud_m,
  output logic      [31:0] aud_n,
  output logic             extension_packet_sent_irq
);

  localparam int AW = $clog2(BUF_DEPTH);
  localparam int PW = AW + 1;
  localparam int NW = $clog2(NAUD_ASYNC + 1);
  localparam int TW = $clog2(INFO_PERIOD + 1);

  initial begin
    if (BUF_DEPTH < 2 * ASP_PKT_WORDS) $error("asp_packetizer: BUF_DEPTH must hold two packets");
    if (INFO_PERIOD < 2 || NAUD_ASYNC < 2) $error("asp_packetizer: periods too short");
  end

  // ---------------- Register bus ----------------
  logic        ph_wr;
  logic [11:0] ph_addr;
  logic        ctrl_en;
  logic        clk_sync;
  logic [2:0]  chan_cnt;
  logic [31:0] audio_m_value_reg;
  logic [31:0] audio_n_value_reg;
  logic [31:0] info_word [ASP_PKT_WORDS];
  logic [31:0] extension_packet_buffer [ASP_PKT_WORDS];
  logic        info_valid;
  logic        ext_pending;
  logic        ext_sent;
  logic        ext_done;
  logic        addr_take;
  logic [31:0] next_hrdata;

  assign addr_take = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 12'h000;
    end else if (ce) begin
      ph_wr   <= addr_take && hwrite;
      ph_addr <= haddr[11:0];
    end
  end

  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr[11:5] == ASP_OFF_INFO[11:5]) begin
      next_hrdata = info_word[haddr[4:2]];
    end else if (haddr[11:5] == ASP_OFF_EXT[11:5]) begin
      next_hrdata = extension_packet_buffer[haddr[4:2]];
    end else begin
      unique case (haddr[11:0])
        ASP_OFF_CTRL:     next_hrdata[ASP_CTRL_EN_BIT] = ctrl_en;
        ASP_OFF_CHANNELS: next_hrdata[2:0] = chan_cnt;
        ASP_OFF_M:        next_hrdata = audio_m_value_reg;
        ASP_OFF_N:        next_hrdata = audio_n_value_reg;
        ASP_OFF_CLKMODE:  next_hrdata[ASP_CLKMODE_SYNC_BIT] = clk_sync;
        ASP_OFF_STATUS: begin
          next_hrdata[ASP_ST_ENABLED_BIT]  = ctrl_en;
          next_hrdata[ASP_ST_EXT_BUSY_BIT] = ext_pending;
          next_hrdata[ASP_ST_EXT_SENT_BIT] = ext_sent;
          next_hrdata[ASP_ST_INFO_OK_BIT]  = info_valid;
          next_hrdata[ASP_ST_MUTE_BIT]     = vbid_mute;
        end
        ASP_OFF_M_ACT:    next_hrdata = aud_m;
        ASP_OFF_N_ACT:    next_hrdata = aud_n;
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // Control, channel count, M/N and clock mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en           <= 1'b0;
      clk_sync          <= 1'b0;
      chan_cnt          <= ASP_RST_CHANNELS;
      audio_m_value_reg <= ASP_RST_M;
      audio_n_value_reg <= ASP_RST_N;
    end else if (ce && ph_wr) begin
      unique case (ph_addr)
        ASP_OFF_CTRL:     ctrl_en <= hwdata[ASP_CTRL_EN_BIT]; // RL9 RL13
        ASP_OFF_CHANNELS: chan_cnt <= hwdata[2:0];
        ASP_OFF_M:        audio_m_value_reg <= hwdata;
        ASP_OFF_N:        audio_n_value_reg <= hwdata;
        ASP_OFF_CLKMODE:  clk_sync <= hwdata[ASP_CLKMODE_SYNC_BIT];
        default:          ;
      endcase
    end
  end

  // Info packet words; a write to the eighth word completes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      info_valid <= 1'b0;
      for (int i = 0; i < ASP_PKT_WORDS; i++) info_word[i] <= 32'h0000_0000;
    end else if (ce && ph_wr && ph_addr[11:5] == ASP_OFF_INFO[11:5]) begin
      info_word[ph_addr[4:2]] <= hwdata;
      info_valid <= (ph_addr[4:2] == 3'(ASP_PKT_WORDS - 1));
    end
  end

  // Extension buffer; writes while a packet is pending are dropped so it cannot tear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_pending <= 1'b0;
      for (int i = 0; i < ASP_PKT_WORDS; i++) extension_packet_buffer[i] <= 32'h0000_0000;
    end else if (ce) begin
      if (ext_done) begin
        ext_pending <= 1'b0; // RL21
      end else if (ph_wr && !ext_pending && ph_addr[11:5] == ASP_OFF_EXT[11:5]) begin
        extension_packet_buffer[ph_addr[4:2]] <= hwdata;
        if (ph_addr[4:2] == 3'(ASP_PKT_WORDS - 1)) ext_pending <= 1'b1; // RL18
      end
    end
  end

  // Sticky sent flag, write one to clear; a new completion wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sent                  <= 1'b0;
      extension_packet_sent_irq <= 1'b0;
    end else if (ce) begin
      extension_packet_sent_irq <= ext_done; // RL21
      if (ext_done) begin
        ext_sent <= 1'b1;
      end else if (ph_wr && ph_addr == ASP_OFF_STATUS && hwdata[ASP_ST_EXT_SENT_BIT]) begin
        ext_sent <= 1'b0;
      end
    end
  end

  // ---------------- Ingress buffer ----------------
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] level;
  logic          push;
  logic          pop;
  logic [39:0]   rd_word;

  assign level               = wr_ptr - rd_ptr;
  assign s_axis_audio_tready = ctrl_en && (level < PW'(BUF_DEPTH)); // RL3 RL22
  assign push                = s_axis_audio_tvalid && s_axis_audio_tready; // RL2

  // Disable empties the buffer at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (!ctrl_en) begin
        wr_ptr <= '0; // RL9
        rd_ptr <= '0;
      end else begin
        if (push) wr_ptr <= wr_ptr + PW'(1);
        if (pop) rd_ptr <= rd_ptr + PW'(1);
      end
    end
  end

  // Sample word kept whole with its channel tag
  asp_sample_mem #(
    .WIDTH (40),
    .DEPTH (BUF_DEPTH)
  ) u_mem (
    .clk     (hclk),
    .ce      (ce),
    .wr_en   (push),
    .wr_addr (wr_ptr[AW-1:0]),
    .wr_data ({s_axis_audio_tid, s_axis_audio_tdata}), // RL1
    .rd_en   (pop),
    .rd_addr (rd_ptr[AW-1:0]),
    .rd_data (rd_word)
  );

  // ---------------- Audio clock recovery ----------------
  logic          ref_s1;
  logic          ref_s2;
  logic          ref_s3;
  logic [NW-1:0] win_cnt;
  logic [31:0]   ref_cnt;
  logic [31:0]   meas_m;
  logic          win_end;

  assign win_end = (win_cnt == NW'(NAUD_ASYNC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1  <= 1'b0;
      ref_s2  <= 1'b0;
      ref_s3  <= 1'b0;
      win_cnt <= '0;
      ref_cnt <= 32'h0000_0000;
      meas_m  <= 32'h0000_0000;
    end else if (ce) begin
      ref_s1  <= aud_ref_clk;
      ref_s2  <= ref_s1;
      ref_s3  <= ref_s2;
      win_cnt <= win_end ? '0 : win_cnt + NW'(1);
      // Reference edges per link window give M against the fixed N; RL12
      if (win_end) begin
        meas_m  <= ref_cnt + 32'(ref_s2 && !ref_s3);
        ref_cnt <= 32'h0000_0000;
      end else if (ref_s2 && !ref_s3) begin
        ref_cnt <= ref_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aud_m     <= 32'h0000_0000;
      aud_n     <= 32'h0000_0000;
      vbid_mute <= 1'b1;
    end else if (ce) begin
      aud_m     <= clk_sync ? audio_m_value_reg : meas_m; // RL12
      aud_n     <= clk_sync ? audio_n_value_reg : 32'(NAUD_ASYNC);
      vbid_mute <= !ctrl_en; // RL9
    end
  end

  // ---------------- Info timer ----------------
  logic [TW-1:0] info_timer;
  logic          info_due;
  logic          info_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      info_timer <= '0;
      info_due   <= 1'b0;
    end else if (ce) begin
      info_timer <= (frame_start || info_timer == TW'(INFO_PERIOD - 1)) ? '0 : info_timer + TW'(1);
      if (frame_start || info_timer == TW'(INFO_PERIOD - 1)) begin
        info_due <= 1'b1; // RL15
      end else if (info_go) begin
        info_due <= 1'b0;
      end
    end
  end

  // ---------------- Packet engine ----------------
  asp_state_t  state;
  asp_kind_t   kind;
  logic [3:0]  load_cnt;
  logic [5:0]  byte_idx;
  logic [31:0] hdr;
  logic [31:0] pay [ASP_PKT_WORDS];
  logic        beat;
  logic        last_beat;
  logic        audio_go;
  logic        ext_go;

  assign beat      = sec_valid && sec_ready;
  assign last_beat = beat && byte_idx == 6'(ASP_PKT_BYTES - 1);
  assign ext_go    = (state == ASP_S_IDLE) && ext_pending; // RL17
  assign info_go   = (state == ASP_S_IDLE) && !ext_pending && info_due && info_valid && ctrl_en; // RL15
  assign audio_go  = (state == ASP_S_IDLE) && !ext_pending && !(info_due && info_valid && ctrl_en)
                     && ctrl_en && level >= PW'(ASP_PKT_WORDS); // RL5 RL22
  assign pop       = (state == ASP_S_LOAD) && load_cnt < 4'(ASP_PKT_WORDS) && ctrl_en;
  assign ext_done  = last_beat && kind == ASP_KIND_EXT; // RL21

  // Byte order: header, header parity, payload, payload parity
  function automatic logic [7:0] pkt_byte(input logic [5:0] idx, input logic [31:0] h,
                                          input logic [255:0] p);
    logic [7:0] r;
    int         k;
    r = 8'h00;
    if (idx < 6'(ASP_HDR_BYTES)) begin
      r = h[8*idx +: 8];
    end else if (idx < 6'(ASP_HDR_BYTES + ASP_HDR_PAR_BYTES)) begin
      k = int'(idx) - ASP_HDR_BYTES;
      r = h[8*k +: 8] ^ h[8*((k+1)%4) +: 8];
    end else if (idx < 6'(ASP_HDR_BYTES + ASP_HDR_PAR_BYTES + ASP_PAY_BYTES)) begin
      k = int'(idx) - ASP_HDR_BYTES - ASP_HDR_PAR_BYTES;
      r = p[8*k +: 8];
    end else begin
      k = int'(idx) - ASP_HDR_BYTES - ASP_HDR_PAR_BYTES - ASP_PAY_BYTES;
      for (int m = 0; m < ASP_PAY_BYTES / ASP_PAY_PAR_BYTES; m++) r = r ^ p[8*(8*m+k) +: 8];
    end
    return r;
  endfunction : pkt_byte

  logic [255:0] pay_flat;
  always_comb begin
    pay_flat = '0;
    for (int i = 0; i < ASP_PKT_WORDS; i++) pay_flat[32*i +: 32] = pay[i];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ASP_S_IDLE;
      kind      <= ASP_KIND_AUDIO;
      load_cnt  <= 4'h0;
      byte_idx  <= 6'h00;
      hdr       <= 32'h0000_0000;
      sec_valid <= 1'b0;
      sec_data  <= 8'h00;
      sec_sop   <= 1'b0;
      sec_eop   <= 1'b0;
      for (int i = 0; i < ASP_PKT_WORDS; i++) pay[i] <= 32'h0000_0000;
    end else if (ce) begin
      unique case (state)
        ASP_S_IDLE: begin
          byte_idx <= 6'h00;
          load_cnt <= 4'h0;
          if (ext_go) begin
            kind <= ASP_KIND_EXT;
            hdr  <= {8'h00, 8'h00, ASP_TYPE_EXT, 8'h00};
            for (int i = 0; i < ASP_PKT_WORDS; i++) pay[i] <= extension_packet_buffer[i];
            state <= ASP_S_LOAD;
          end else if (info_go) begin
            kind <= ASP_KIND_INFO;
            hdr  <= {8'h00, 8'h00, ASP_TYPE_INFO, 8'h00};
            for (int i = 0; i < ASP_PKT_WORDS; i++) pay[i] <= info_word[i];
            state <= ASP_S_LOAD;
          end else if (audio_go) begin
            kind  <= ASP_KIND_AUDIO;
            state <= ASP_S_LOAD;
          end
        end
        ASP_S_LOAD: begin
          if (kind == ASP_KIND_AUDIO && !ctrl_en) begin
            state <= ASP_S_IDLE; // RL22
          end else if (kind != ASP_KIND_AUDIO || load_cnt == 4'(ASP_PKT_WORDS)) begin
            state     <= ASP_S_SEND;
            sec_valid <= 1'b1;
            sec_sop   <= 1'b1;
            sec_data  <= hdr[7:0];
          end else begin
            load_cnt <= load_cnt + 4'h1;
          end
          // Read data lands one cycle after each pop
          if (kind == ASP_KIND_AUDIO && load_cnt != 4'h0) begin
            pay[load_cnt[2:0] - 3'h1] <= rd_word[31:0];
            if (load_cnt == 4'h1) hdr <= {5'h00, chan_cnt, 4'h0, rd_word[39:36], ASP_TYPE_AUDIO, 8'h00};
          end
        end
        ASP_S_SEND: begin
          if (kind == ASP_KIND_AUDIO && !ctrl_en) begin
            state     <= ASP_S_IDLE; // RL22
            sec_valid <= 1'b0;
            sec_sop   <= 1'b0;
            sec_eop   <= 1'b0;
          end else if (last_beat) begin
            state     <= ASP_S_IDLE;
            sec_valid <= 1'b0;
            sec_eop   <= 1'b0;
          end else if (beat) begin
            byte_idx <= byte_idx + 6'h01;
            sec_data <= pkt_byte(byte_idx + 6'h01, hdr, pay_flat); // RL4
            sec_sop  <= 1'b0;
            sec_eop  <= (byte_idx == 6'(ASP_PKT_BYTES - 2));
          end
        end
      endcase
    end
  end

  assign sec_kind = kind;

  // ---------------- Assertions ----------------
  sequence s_ext_last;
    ce && ext_done;
  endsequence

  sequence s_irq_pulse;
    extension_packet_sent_irq && !ext_pending;
  endsequence

  property p_handshake;
    @(posedge hclk) disable iff (!hresetn) ce && push |=> wr_ptr == $past(wr_ptr) + PW'(1);
  endproperty
  a_handshake: assert property (p_handshake) else $error("Accepted sample did not advance buffer"); // RL2

  property p_ready_room;
    @(posedge hclk) disable iff (!hresetn) s_axis_audio_tready |-> ctrl_en && level < PW'(BUF_DEPTH);
  endproperty
  a_ready_room: assert property (p_ready_room) else $error("Ready without room or enable"); // RL3

  property p_pkt_len;
    @(posedge hclk) disable iff (!hresetn) sec_eop && beat |-> byte_idx == 6'(ASP_PKT_BYTES - 1);
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("Packet length is not 48 bytes"); // RL4

  property p_audio_eight;
    @(posedge hclk) disable iff (!hresetn) ce && audio_go |-> level >= PW'(ASP_PKT_WORDS) ##1 state == ASP_S_LOAD;
  endproperty
  a_audio_eight: assert property (p_audio_eight) else $error("Audio packet started short of eight samples"); // RL5

  property p_flush;
    @(posedge hclk) disable iff (!hresetn) ce && !ctrl_en |=> level == '0 && vbid_mute;
  endproperty
  a_flush: assert property (p_flush) else $error("Disable did not flush or mute"); // RL9

  property p_mn_async;
    @(posedge hclk) disable iff (!hresetn) ce && win_end && !clk_sync ##1 ce |=> aud_m == $past(meas_m);
  endproperty
  a_mn_async: assert property (p_mn_async) else $error("Measured M not presented"); // RL12

  property p_info_due;
    @(posedge hclk) disable iff (!hresetn) ce && info_timer == TW'(INFO_PERIOD - 1) |=> info_due;
  endproperty
  a_info_due: assert property (p_info_due) else $error("Info packet not scheduled at period"); // RL15

  property p_ext_sent;
    @(posedge hclk) disable iff (!hresetn) s_ext_last |=> s_irq_pulse ##1 !extension_packet_sent_irq;
  endproperty
  a_ext_sent: assert property (p_ext_sent) else $error("Extension sent pulse missing"); // RL21

  property p_no_audio_disabled;
    @(posedge hclk) disable iff (!hresetn) !ctrl_en |-> !s_axis_audio_tready && !audio_go;
  endproperty
  a_no_audio_disabled: assert property (p_no_audio_disabled) else $error("Audio activity while disabled"); // RL22

endmodule : asp_packetizer

// ==== verif/asp_audio_src.sv ====
`timescale 1ns/10ps
module asp_audio_src (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Request for eight samples
  input  wire logic        go,
  input  wire logic [3:0]  stream_id,
  // Stream out
  output logic      [31:0] tdata,
  output logic      [7:0]  tid,
  output logic             tvalid,
  input  wire logic        tready
);
  logic [4:0] left;
  logic [4:0] idx;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tvalid <= 1'b0;
      tdata  <= 32'h0000_0000;
      tid    <= 8'h00;
      left   <= 5'h00;
      idx    <= 5'h00;
    end else if (go) begin
      left <= 5'h08;
      idx  <= 5'h00;
    end else if (!tvalid || tready) begin
      tvalid <= (left != 5'h00);
      // Idle data keeps changing so nothing leans on a stale word
      tdata  <= (left != 5'h00) ? 32'h0055_AA00 + {27'h0, idx} : ~tdata;
      tid    <= {stream_id, 3'h0, idx[0]};
      left   <= (left != 5'h00) ? left - 5'h01 : left;
      idx    <= idx + 5'h01;
    end
  end
endmodule : asp_audio_src

// ==== verif/asp_packetizer_tb_top.sv ====
`timescale 1ns/10ps
module asp_packetizer_tb_top;
  import asp_pkg::*;
  logic        hclk, hresetn, hwrite, sec_ready, go, aud_ref_clk, hreadyout, hresp, tvalid, tready;
  logic        sec_valid, sec_sop, sec_eop, vbid_mute, irq, ce, frame_start;
  logic [1:0]  htrans, sec_kind;
  logic [7:0]  tid, sec_data;
  logic [31:0] haddr, hwdata, hrdata, tdata, aud_m, aud_n, q;
  logic [7:0]  pkt[48];
  int          err_count, total_checks;

  asp_packetizer #(.INFO_PERIOD(64), .NAUD_ASYNC(256)) dut_u (
    .hclk, .hresetn, .ce, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .s_axis_audio_tdata(tdata), .s_axis_audio_tid(tid),
    .s_axis_audio_tvalid(tvalid), .s_axis_audio_tready(tready), .frame_start, .aud_ref_clk,
    .sec_data, .sec_valid, .sec_ready, .sec_kind, .sec_sop, .sec_eop, .vbid_mute, .aud_m, .aud_n,
    .extension_packet_sent_irq(irq));
  asp_audio_src src_u (.hclk, .hresetn, .go, .stream_id(4'h3), .tdata, .tid, .tvalid, .tready);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    aud_ref_clk = 1'b0;
    forever #10 aud_ref_clk = ~aud_ref_clk;
  end
  // The link stalls every other cycle
  always @(posedge hclk) sec_ready <= ~sec_ready;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb

  task automatic grab(input logic [1:0] kind);
    int n, i;
    n = 0;
    i = 0;
    while (i < 48 && n < 3000) begin
      @(negedge hclk);
      n++;
      if (sec_valid === 1'b1 && sec_ready === 1'b1) begin
        pkt[i] = sec_data;
        chk({sec_sop, sec_eop, sec_kind}, {i == 0, i == 47, kind});
        i++;
      end
    end
    if (i < 48) begin
      err_count++;
      close_out();
    end
  endtask : grab

  function automatic logic [7:0] pb(input logic [31:0] base, input int b);
    return 8'((base + 32'(b / 4)) >> (8 * (b % 4)));
  endfunction : pb

  task automatic check_pkt(input logic [7:0] ty, input logic [7:0] hb2, input logic [7:0] hb3,
                           input logic [31:0] base);
    logic [7:0] hb[4];
    hb = '{8'h00, ty, hb2, hb3};
    for (int k = 0; k < 4; k++) begin
      chk(pkt[k], hb[k]);
      chk(pkt[4+k], hb[k] ^ hb[(k+1)%4]);
    end
    for (int b = 0; b < 32; b++) chk(pkt[8+b], pb(base, b));
    for (int j = 0; j < 8; j++) chk(pkt[40+j], pb(base, j) ^ pb(base, j+8) ^ pb(base, j+16) ^ pb(base, j+24));
  endtask : check_pkt

  task automatic ext_pkt();
    for (int k = 0; k < 8; k++) ahb(1'b1, ASP_OFF_EXT + 12'(4*k), 32'hE100_0000 + k);
    grab(2'h2);
    check_pkt(ASP_TYPE_EXT, 8'h00, 8'h00, 32'hE100_0000);
    @(negedge hclk);
    chk(irq, 1'b1);
    @(negedge hclk);
    chk(irq, 1'b0);
    ahb(1'b0, ASP_OFF_STATUS, 32'h0);
    chk(q[2:1], 2'b10);
  endtask : ext_pkt

  task automatic audio_pkt();
    ahb(1'b1, ASP_OFF_CHANNELS, 32'h1);
    ahb(1'b1, ASP_OFF_M, 32'h0000_1234);
    ahb(1'b1, ASP_OFF_N, 32'h0000_5678);
    ahb(1'b1, ASP_OFF_CLKMODE, 32'h1);
    ahb(1'b1, ASP_OFF_CTRL, 32'h1);
    @(negedge hclk);
    chk(tready, 1'b1);
    chk(aud_m ^ aud_n, 32'h0000_444C);
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    grab(2'h0);
    check_pkt(ASP_TYPE_AUDIO, 8'h03, 8'h01, 32'h0055_AA00);
  endtask : audio_pkt

  task automatic async_and_off();
    ahb(1'b1, ASP_OFF_CLKMODE, 32'h0);
    repeat (600) @(negedge hclk);
    chk(aud_n, 32'd256);
    chk(aud_m >= 32'd50 && aud_m <= 32'd52, 1'b1);
    ahb(1'b1, ASP_OFF_CTRL, 32'h0);
    repeat (2) @(negedge hclk);
    chk({tready, vbid_mute}, 2'b01);
    ahb(1'b0, ASP_OFF_STATUS, 32'h0);
    chk(q[4:0] & 5'h11, 5'h10);
  endtask : async_and_off

  task automatic info_pkt();
    ahb(1'b1, ASP_OFF_CTRL, 32'h0);
    for (int k = 0; k < 8; k++) ahb(1'b1, ASP_OFF_INFO + 12'(4*k), 32'h1F00_0000 + k);
    ahb(1'b1, ASP_OFF_CTRL, 32'h1);
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    grab(2'h1);
    check_pkt(ASP_TYPE_INFO, 8'h00, 8'h00, 32'h1F00_0000);
  endtask : info_pkt

  initial begin
    {hresetn, hwrite, sec_ready, go, ce, frame_start, htrans, haddr, hwdata, err_count, total_checks} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({tready, vbid_mute}, 2'b01);
    // Frozen by the enable, so this write must not land
    ahb(1'b1, ASP_OFF_CHANNELS, 32'h5);
    ce <= 1'b1;
    ahb(1'b0, ASP_OFF_CHANNELS, 32'h0);
    chk(q, 32'(ASP_RST_CHANNELS));
    ahb(1'b0, 12'h0FC, 32'h0);
    chk(q, 32'h0000_0000);
    ext_pkt();
    audio_pkt();
    async_and_off();
    info_pkt();
    close_out();
  end
endmodule : asp_packetizer_tb_top
